// File: design/occc_regs.vh
// Register map, field layout, reset values and encodings of the
// output channel clock configuration block.
// Assumes a 32-bit AHB-Lite bus, one register per aligned word.
`ifndef OCCC_REGS_VH
`define OCCC_REGS_VH

// Register indices; the byte address is four times the index
`define OCCC_IDX_CONTROL        8'h27
`define OCCC_IDX_DIVIDER        8'h28
`define OCCC_IDX_STATUS         8'h29

// Byte addresses on the bus
`define OCCC_ADDR_CONTROL       12'h09C
`define OCCC_ADDR_DIVIDER       12'h0A0
`define OCCC_ADDR_STATUS        12'h0A4
`define OCCC_ADDR_W             12

// Control register field positions
`define OCCC_SRC_HI             7
`define OCCC_SRC_LO             6
`define OCCC_FMT_HI             5
`define OCCC_FMT_LO             4
`define OCCC_MODEP_HI           3
`define OCCC_MODEP_LO           2
`define OCCC_MODEN_HI           1
`define OCCC_MODEN_LO           0

// Reset values
`define OCCC_RST_SRC            2'h0
`define OCCC_RST_FMT            2'h1
`define OCCC_RST_MODEP          2'h2
`define OCCC_RST_MODEN          2'h0
`define OCCC_RST_DIVIDER        8'h02

// Channel source codes
`define OCCC_SRC_SYNTH_ONE      2'h0
`define OCCC_SRC_SYNTH_TWO      2'h1
`define OCCC_SRC_REF_PRIMARY    2'h2
`define OCCC_SRC_REF_SECONDARY  2'h3

// Driver format codes
`define OCCC_FMT_DISABLED       2'h0
`define OCCC_FMT_AC_DIFF        2'h1
`define OCCC_FMT_HCSL           2'h2
`define OCCC_FMT_LVCMOS         2'h3

// Driver mode codes in LVCMOS format
`define OCCC_MODE_OFF_TRI       2'h0
`define OCCC_MODE_OFF_LOW       2'h1
`define OCCC_MODE_ON_INV        2'h2
`define OCCC_MODE_ON_TRUE       2'h3

// Tail current in mA and load resistance in ohms
`define OCCC_TAIL_MA_0          5'h04
`define OCCC_TAIL_MA_1          5'h06
`define OCCC_TAIL_MA_2          5'h08
`define OCCC_TAIL_MA_3_HCSL     5'h10
`define OCCC_TAIL_MA_3_AC       5'h08
`define OCCC_RLOAD_1            8'h32
`define OCCC_RLOAD_2            8'h64
`define OCCC_RLOAD_3            8'hC8

// AHB transfer type bit that marks an active transfer
`define OCCC_HTRANS_ACTIVE_BIT  1

`endif

// File: design/occc_div.v
// Channel output divider: passes one output tick per (ratio + 1)
// input ticks, or every input tick when bypassed.
// Assumes input ticks are one-cycle pulses synchronous to hclk.
`timescale 1ns/10ps

module occc_div (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Divider control
  input  wire       bypass,
  input  wire [7:0] ratio,
  // Tick stream
  input  wire       tick_in,
  output reg        tick_out,
  output reg  [7:0] count
);

  // Terminal count reached; also wraps if ratio shrinks below count
  wire at_end;
  assign at_end = (count >= ratio);

  // Count source ticks and emit one at the end of each period
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (bypass) begin
      count    <= 8'h00;
      tick_out <= tick_in;
    end else if (tick_in) begin
      if (at_end) begin
        count    <= 8'h00;
        tick_out <= 1'b1;
      end else begin
        count    <= count + 8'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule // occc_div

// File: design/occc_top.v
// Output channel clock configuration: AHB-Lite register slave, source
// select, output divider and driver format and mode decoding.
// Assumes source clocks arrive as one-cycle tick enables on hclk.
// Assumes hready is looped back from hreadyout on a single-slave bus.
//
// What this block does
// - Source field bits 7:6 picks synth one, synth two, primary or secondary ref.
// - With doubler on, reference choices deliver the doubled reference instead.
// - Picking a reference bypasses the output divider entirely.
// - Format field bits 5:4: disabled, AC differential, HCSL, LVCMOS; reset 1.
// - LVCMOS: primary mode bits 3:2 drive positive pin; reset 2.
// - LVCMOS: secondary mode bits 1:0 drive negative pin; reset 0.
// - Differential: primary mode selects tail current 4, 6, 8, 16/8 mA.
// - HCSL: secondary mode selects tri-state, 50, 100 or 200 ohm load.
// - Eight-bit divider value divides by value plus one, 1 to 256.
// - Divider acts only when a synthesizer is the source.
`timescale 1ns/10ps
`include "occc_regs.vh"

module occc_top (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Source clock ticks
  input  wire        synth_one_tick,
  input  wire        synth_two_tick,
  input  wire        ref_primary_tick,
  input  wire        ref_secondary_tick,
  input  wire        ref_primary_x2_tick,
  input  wire        ref_secondary_x2_tick,
  input  wire        doubler_enable,
  // Channel clock
  output wire        channel_tick,
  output reg         channel_clk,
  // Driver pins
  output reg         out_p,
  output reg         out_p_oe,
  output reg         out_n,
  output reg         out_n_oe,
  // Driver analog settings
  output reg  [1:0]  driver_format,
  output reg  [4:0]  tail_current_ma,
  output reg  [7:0]  load_ohms
);

  // Register fields; each holds its printed default from reset onward
  // until software writes the register that carries it
  reg  [1:0] channel_source_select;
  reg  [1:0] driver_format_select;
  reg  [1:0] driver_mode_primary;
  reg  [1:0] driver_mode_secondary;
  reg  [7:0] divider_value;

  // Data phase state; the decoded register is kept rather than the
  // address, so writes see the same full decode as reads
  reg        dp_write;
  reg  [1:0] dp_sel;

  // Channel path
  reg        source_tick;
  wire       bypass_div;
  wire       div_tick;

  // Register selected by a byte address: 0 none, 1 control, 2 divider,
  // 3 status; full decode so aliases above the block answer zero
  // and, since the data phase keeps this code, ignore writes as well
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr == {20'h0_0000, `OCCC_ADDR_CONTROL}) begin
        reg_sel = 2'h1;
      end else if (addr == {20'h0_0000, `OCCC_ADDR_DIVIDER}) begin
        reg_sel = 2'h2;
      end else if (addr == {20'h0_0000, `OCCC_ADDR_STATUS}) begin
        reg_sel = 2'h3;
      end else begin
        reg_sel = 2'h0;
      end
    end
  endfunction

  // LVCMOS pin from one mode code: returns {oe, level}
  // Codes 0 and 1 power the pin down; only 2 and 3 follow the clock
  function [1:0] cmos_pin;
    input [1:0] mode;
    input       clk;
    begin
      if (mode == `OCCC_MODE_OFF_TRI) begin
        cmos_pin = 2'h0;
      end else if (mode == `OCCC_MODE_OFF_LOW) begin
        cmos_pin = 2'h2;
      end else if (mode == `OCCC_MODE_ON_INV) begin
        cmos_pin = {1'b1, ~clk};
      end else begin
        cmos_pin = {1'b1, clk};
      end
    end
  endfunction

  // Zero wait states and no error replies keep the master simple
  // Every register is a flop, so a read never needs an extra cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // A transfer is taken in its address phase when selected and ready
  wire take = hsel & hready & htrans[`OCCC_HTRANS_ACTIVE_BIT];
  wire [1:0] addr_sel = reg_sel(haddr);

  // Remember the address phase for the following data phase; while
  // hready is low another slave stretches its data phase, so hold still
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_sel   <= 2'h0;
    end else if (hready) begin
      dp_write <= take & hwrite;
      dp_sel   <= addr_sel;
    end
  end

  // Register writes land in the data phase; only the low byte is stored
  // Status and unmapped addresses decode to no writable register, so writes there
  // change nothing and still answer OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_source_select <= `OCCC_RST_SRC;
      driver_format_select  <= `OCCC_RST_FMT;
      driver_mode_primary   <= `OCCC_RST_MODEP;
      driver_mode_secondary <= `OCCC_RST_MODEN;
      divider_value         <= `OCCC_RST_DIVIDER;
    end else if (dp_write) begin
      if (dp_sel == 2'h1) begin
        channel_source_select <= hwdata[`OCCC_SRC_HI:`OCCC_SRC_LO];
        driver_format_select  <= hwdata[`OCCC_FMT_HI:`OCCC_FMT_LO];
        driver_mode_primary   <= hwdata[`OCCC_MODEP_HI:`OCCC_MODEP_LO];
        driver_mode_secondary <= hwdata[`OCCC_MODEN_HI:`OCCC_MODEN_LO];
      end else if (dp_sel == 2'h2) begin
        divider_value <= hwdata[7:0];
      end
    end
  end

  // Current register contents as they read on the bus
  // Status bits 4:2 are reserved and read zero
  wire [7:0] control_word = {channel_source_select, driver_format_select,
                             driver_mode_primary, driver_mode_secondary};
  wire [7:0] status_word  = {bypass_div, channel_clk, doubler_enable,
                             3'h0, channel_source_select};

  // Read data is fetched in the address phase so it stands in the data
  // phase; a write to the same register just before is forwarded
  // Status is never forwarded, as software cannot write it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      if (addr_sel == 2'h1) begin
        if (dp_write && dp_sel == 2'h1) begin
          hrdata <= {24'h00_0000, hwdata[7:0]};
        end else begin
          hrdata <= {24'h00_0000, control_word};
        end
      end else if (addr_sel == 2'h2) begin
        if (dp_write && dp_sel == 2'h2) begin
          hrdata <= {24'h00_0000, hwdata[7:0]};
        end else begin
          hrdata <= {24'h00_0000, divider_value};
        end
      end else if (addr_sel == 2'h3) begin
        hrdata <= {24'h00_0000, status_word};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Source mux; references follow the doubler when it is on
  // The doubler choice is made per tick, so toggling it takes effect on
  // the next reference tick with no register write needed
  always @* begin
    case (channel_source_select)
      `OCCC_SRC_SYNTH_ONE: begin
        source_tick = synth_one_tick;
      end
      `OCCC_SRC_SYNTH_TWO: begin
        source_tick = synth_two_tick;
      end
      `OCCC_SRC_REF_PRIMARY: begin
        source_tick = doubler_enable ? ref_primary_x2_tick
                                     : ref_primary_tick;
      end
      default: begin
        source_tick = doubler_enable ? ref_secondary_x2_tick
                                     : ref_secondary_tick;
      end
    endcase
  end

  // Divider only runs for synthesizer sources; both reference codes have
  // the upper bit set, so one bit decides
  assign bypass_div = channel_source_select[1];

  // The divider clears its count while bypassed, so a later return to a
  // synthesizer starts a full period; the running count is not needed
  occc_div i_occc_div (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .bypass   (bypass_div),
    .ratio    (divider_value),
    .tick_in  (source_tick),
    .tick_out (div_tick),
    .count    ()
  );

  assign channel_tick = div_tick;

  // Channel clock level flips on every divided tick; output is held
  // low while the format is disabled so the driver idles quietly
  // Disabling also restarts the phase low, so a later enable always
  // opens with a rising edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_clk <= 1'b0;
    end else if (driver_format_select == `OCCC_FMT_DISABLED) begin
      channel_clk <= 1'b0;
    end else if (div_tick) begin
      channel_clk <= ~channel_clk;
    end
  end

  // Driver pins and analog settings, registered to avoid glitches
  // Pins trail channel_clk by one cycle; that flop keeps the format and
  // mode decode off the pin timing. Analog settings read zero where they
  // do not apply. Reset leaves the driver quiet although the format
  // field defaults to differential; the first edge after release wakes it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_p           <= 1'b0;
      out_p_oe        <= 1'b0;
      out_n           <= 1'b0;
      out_n_oe        <= 1'b0;
      driver_format   <= `OCCC_RST_FMT;
      tail_current_ma <= 5'h00;
      load_ohms       <= 8'h00;
    end else begin
      driver_format <= driver_format_select;
      case (driver_format_select)
        `OCCC_FMT_LVCMOS: begin
          {out_p_oe, out_p} <= cmos_pin(driver_mode_primary, channel_clk);
          {out_n_oe, out_n} <= cmos_pin(driver_mode_secondary, channel_clk);
          tail_current_ma   <= 5'h00;
          load_ohms         <= 8'h00;
        end
        `OCCC_FMT_AC_DIFF, `OCCC_FMT_HCSL: begin
          out_p    <= channel_clk;
          out_n    <= ~channel_clk;
          out_p_oe <= 1'b1;
          // HCSL secondary code 0 leaves the load tri-stated
          out_n_oe <= (driver_format_select != `OCCC_FMT_HCSL) ||
                      (driver_mode_secondary != 2'h0);
          case (driver_mode_primary)
            2'h0: tail_current_ma <= `OCCC_TAIL_MA_0;
            2'h1: tail_current_ma <= `OCCC_TAIL_MA_1;
            2'h2: tail_current_ma <= `OCCC_TAIL_MA_2;
            default: begin
              tail_current_ma <= (driver_format_select == `OCCC_FMT_HCSL) ?
                                 `OCCC_TAIL_MA_3_HCSL : `OCCC_TAIL_MA_3_AC;
            end
          endcase
          if (driver_format_select != `OCCC_FMT_HCSL) begin
            load_ohms <= 8'h00;
          end else if (driver_mode_secondary == 2'h1) begin
            load_ohms <= `OCCC_RLOAD_1;
          end else if (driver_mode_secondary == 2'h2) begin
            load_ohms <= `OCCC_RLOAD_2;
          end else if (driver_mode_secondary == 2'h3) begin
            load_ohms <= `OCCC_RLOAD_3;
          end else begin
            load_ohms <= 8'h00;
          end
        end
        default: begin
          out_p           <= 1'b0;
          out_p_oe        <= 1'b0;
          out_n           <= 1'b0;
          out_n_oe        <= 1'b0;
          tail_current_ma <= 5'h00;
          load_ohms       <= 8'h00;
        end
      endcase
    end
  end

endmodule // occc_top

// File: dv/occc_sva.sv
// Checker for the channel clock configuration block, ports only.
// Assumes a bind onto occc_top and a single hclk domain.
`timescale 1ns/10ps
module occc_sva (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus answer
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // Source ticks
  input wire        synth_one_tick,
  input wire        synth_two_tick,
  input wire        ref_primary_tick,
  input wire        ref_secondary_tick,
  input wire        ref_primary_x2_tick,
  input wire        ref_secondary_x2_tick,
  // Channel and driver
  input wire        channel_tick,
  input wire        channel_clk,
  input wire        out_p,
  input wire        out_n,
  input wire        out_p_oe,
  input wire        out_n_oe,
  input wire [1:0]  driver_format,
  input wire [4:0]  tail_current_ma,
  input wire [7:0]  load_ohms
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Two-cycle antecedents let the registered driver outputs catch up;
  // the edge of reset release is skipped in the two AC checks, as the pins restart from zero
  okay_resp_a: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("hrdata upper bits");
  fmt_off_a: assert property ((driver_format == 2'h0)[*2] |->
    !out_p_oe && !out_n_oe && !channel_clk) else $error("disabled driver active");
  ac_tail_a: assert property (($past(hresetn) && driver_format == 2'h1)[*2] |->
    tail_current_ma inside {5'h04, 5'h06, 5'h08}) else $error("AC tail current");
  hcsl_load_a: assert property ((driver_format == 2'h2)[*2] |->
    load_ohms inside {8'h00, 8'h32, 8'h64, 8'hC8}) else $error("HCSL load");
  diff_pins_a: assert property (($past(hresetn) && driver_format == 2'h1)[*2] |->
    out_p == $past(channel_clk) && out_n != $past(channel_clk)) else $error("diff pins");
  clk_hold_a: assert property (!channel_tick |=> $stable(channel_clk) || !channel_clk)
    else $error("channel clock moved without tick");
  tick_cause_a: assert property (channel_tick |-> $past(synth_one_tick || synth_two_tick
    || ref_primary_tick || ref_secondary_tick || ref_primary_x2_tick || ref_secondary_x2_tick))
    else $error("channel tick without source tick");
endmodule // occc_sva

// File: dv/test_output_channel_clock_config.sv
// Self-checking bench for occc_top over AHB-Lite plus source ticks.
// Assumes hready is looped from hreadyout, single slave on the bus.
`timescale 1ns/10ps
module test_output_channel_clock_config;
  reg          hclk, hresetn, hsel, hwrite, doubler_enable;
  reg  [1:0]   htrans;
  reg  [31:0]  haddr, hwdata, r;
  reg  [5:0]   src;
  wire         hreadyout, hresp, channel_tick, channel_clk, out_p, out_p_oe, out_n, out_n_oe;
  wire [31:0]  hrdata;
  wire [1:0]   driver_format;
  wire [4:0]   tail_current_ma;
  wire [7:0]   load_ohms;
  integer      mismatches, checks_done, m, f;

  occc_top i_occc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .synth_one_tick(src[0]),
    .synth_two_tick(src[1]), .ref_primary_tick(src[2]), .ref_secondary_tick(src[3]),
    .ref_primary_x2_tick(src[4]), .ref_secondary_x2_tick(src[5]),
    .doubler_enable(doubler_enable), .channel_tick(channel_tick), .channel_clk(channel_clk),
    .out_p(out_p), .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe),
    .driver_format(driver_format), .tail_current_ma(tail_current_ma), .load_ohms(load_ohms));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task chk(input [8*8:1] name, input [31:0] exp, input [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single transfer; read data is taken at the edge closing the data phase
  task ahb(input w, input [31:0] a, input [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Control word with source s, format fm, primary mode p, secondary mode q
  task ctl(input [1:0] s, input [1:0] fm, input [1:0] p, input [1:0] q);
    ahb(1'b1, 32'h0000_009C, {24'h00_0000, s, fm, p, q});
    repeat (4) @(posedge hclk);
  endtask

  // Pulse the chosen sources n times and count channel ticks
  task run(input [5:0] which, input integer n, input integer exp);
    integer i, c;
    c = 0;
    for (i = 0; i < n + 4; i = i + 1) begin
      src <= (i < n) ? which : 6'h00;
      @(posedge hclk);
      c = c + channel_tick;
    end
    chk("ticks", exp, c);
  endtask

  task reset_values;
    ahb(1'b0, 32'h0000_009C, 32'h0);
    chk("control", 32'h0000_0018, r);
    ahb(1'b0, 32'h0000_00A0, 32'h0);
    chk("divider", 32'h0000_0002, r);
    chk("format", 32'h1, driver_format);
    chk("tail", 32'h8, tail_current_ma);
    run(6'h01, 30, 10);
  endtask

  task reg_access;
    ahb(1'b1, 32'h0000_00A0, 32'h0000_00A5);
    ahb(1'b0, 32'h0000_00A0, 32'h0);
    chk("divider", 32'h0000_00A5, r);
    ahb(1'b1, 32'h0000_109C, 32'h0000_00FF);
    ahb(1'b0, 32'h0000_009C, 32'h0);
    chk("alias", 32'h0000_0018, r);
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0100, 32'h0);
    chk("unmapped", 32'h0, r);
  endtask

  task divide_and_route;
    ahb(1'b1, 32'h0000_00A0, 32'h0000_00FF);
    run(6'h01, 512, 2);
    ahb(1'b1, 32'h0000_00A0, 32'h0000_0000);
    run(6'h01, 10, 10);
    ahb(1'b1, 32'h0000_00A0, 32'h0000_0001);
    ctl(2'h1, 2'h1, 2'h2, 2'h0);
    run(6'h02, 20, 10);
    run(6'h01, 20, 0);
    // Large ratio proves the reference path skips the divider
    ahb(1'b1, 32'h0000_00A0, 32'h0000_00FF);
    ctl(2'h2, 2'h1, 2'h2, 2'h0);
    ahb(1'b0, 32'h0000_00A4, 32'h0);
    chk("status", 32'h0000_0082, r);
    run(6'h04, 20, 20);
    run(6'h01, 20, 0);
    doubler_enable <= 1'b1;
    run(6'h04, 20, 0);
    run(6'h10, 20, 20);
    ctl(2'h3, 2'h1, 2'h2, 2'h0);
    run(6'h20, 20, 20);
    doubler_enable <= 1'b0;
    run(6'h08, 20, 20);
  endtask

  task driver_modes;
    // 112 channel ticks so far, an even count, leave the channel clock low
    chk("clk", 32'h0, channel_clk);
    for (m = 0; m < 4; m = m + 1) begin
      ctl(2'h0, 2'h3, m[1:0], m[1:0]);
      chk("oe_p", m != 0, out_p_oe);
      chk("oe_n", m != 0, out_n_oe);
      chk("pin_eq", 32'h1, out_p === out_n);
      chk("pin_p", m == 2, out_p);
    end
    ctl(2'h0, 2'h3, 2'h3, 2'h2);
    chk("pin_ne", 32'h1, out_p !== out_n);
    chk("pin_n", 32'h1, out_n);
    for (f = 1; f < 3; f = f + 1) begin
      for (m = 0; m < 4; m = m + 1) begin
        ctl(2'h0, f[1:0], m[1:0], m[1:0]);
        chk("tail", (m == 3) ? ((f == 2) ? 16 : 8) : 4 + 2 * m, tail_current_ma);
        chk("load", (f == 2 && m > 0) ? (25 << m) : 0, load_ohms);
      end
    end
    ctl(2'h0, 2'h2, 2'h0, 2'h0);
    chk("oe_n", 32'h0, out_n_oe);
    ctl(2'h0, 2'h0, 2'h3, 2'h3);
    chk("oe_p", 32'h0, out_p_oe);
    chk("clk", 32'h0, channel_clk);
  endtask

  task tally_and_finish;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the roughly 900 cycles the tests need
  initial begin
    #200000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  initial begin
    mismatches = 0; checks_done = 0;
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    haddr = 32'h0; hwdata = 32'h0; src = 6'h00; doubler_enable = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_values;
    reg_access;
    divide_and_route;
    driver_modes;
    tally_and_finish;
  end
endmodule // test_output_channel_clock_config

bind occc_top occc_sva i_occc_sva (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .synth_one_tick(synth_one_tick),
  .synth_two_tick(synth_two_tick), .ref_primary_tick(ref_primary_tick),
  .ref_secondary_tick(ref_secondary_tick), .ref_primary_x2_tick(ref_primary_x2_tick),
  .ref_secondary_x2_tick(ref_secondary_x2_tick), .channel_tick(channel_tick),
  .channel_clk(channel_clk), .out_p(out_p), .out_n(out_n), .out_p_oe(out_p_oe),
  .out_n_oe(out_n_oe), .driver_format(driver_format), .tail_current_ma(tail_current_ma),
  .load_ohms(load_ohms));
